/* File: logic/cbo_top.v */
/*
 * Clock and buzzer output unit with two channels behind an AXI4-Lite
 * register slave. Each channel drives one output pin with a divided main
 * or subsystem clock.
 * Assumes the core clock is the main system clock and that the subsystem
 * clock input is synchronous to it and much slower.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbo_map.vh"

module cbo_top #(
	parameter ADDR_W = 22,
	parameter N_CH = 2
) (
	input wire core_clk_i,
	input wire reset_i,
	input wire sub_clk_i,
	input wire [ADDR_W-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [ADDR_W-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	output wire [N_CH-1:0] clock_buzzer_pin_o
);

	// ****************************************************************
	// Subsystem clock edge detection
	// ****************************************************************
	reg sub_level_q;
	reg sub_prev_q;
	wire sub_tick;

	// The input is synchronous by contract, so one stage is enough
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			sub_level_q <= 1'b0;
			sub_prev_q <= 1'b0;
		end else begin
			sub_level_q <= sub_clk_i;
			sub_prev_q <= sub_level_q;
		end
	end

	assign sub_tick = sub_level_q & ~sub_prev_q;

	// ****************************************************************
	// Write channel state
	// ****************************************************************
	reg awready_q;
	reg awready_d;
	reg wready_q;
	reg wready_d;
	reg aw_held_q;
	reg aw_held_d;
	reg w_held_q;
	reg w_held_d;
	reg [ADDR_W-1:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg bvalid_d;
	reg [1:0] bresp_q;
	reg [1:0] bresp_d;
	wire aw_take;
	wire w_take;
	wire wr_exec;
	wire [`CBO_IDX_W-1:0] wr_index;
	wire wr_mapped;
	wire [N_CH-1:0] wr_hit;

	assign aw_take = s_axi_awvalid_i & awready_q;
	assign w_take = s_axi_wvalid_i & wready_q;
	assign wr_exec = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_index = aw_addr_q[ADDR_W-1:2];
	assign wr_mapped = (|wr_hit) | (wr_index == `CBO_STATUS_INDEX);

	// Address and data are taken in either order; the answer waits for both
	always @* begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (aw_take) begin
			aw_held_d = 1'b1;
		end
		if (w_take) begin
			w_held_d = 1'b1;
		end
		if (wr_exec) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_mapped ? `CBO_RESP_OKAY : `CBO_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready_i) begin
			bvalid_d = 1'b0;
		end
		// Only one write in flight: no new beats until the answer is gone
		awready_d = ~aw_held_d & ~bvalid_d & ~wr_exec;
		wready_d = ~w_held_d & ~bvalid_d & ~wr_exec;
	end

	always @(posedge core_clk_i) begin
		if (reset_i) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= {ADDR_W{1'b0}};
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `CBO_RESP_OKAY;
		end else begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			if (aw_take) begin
				aw_addr_q <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
		end
	end

	// ****************************************************************
	// Channels: select register and divider per channel
	// ****************************************************************
	wire [8*N_CH-1:0] cks_flat;
	wire [N_CH-1:0] pin_w;
	reg [N_CH-1:0] pin_q;

	genvar n;
	generate
		for (n = 0; n < N_CH; n = n + 1) begin : gen_ch
			localparam [`CBO_IDX_W-1:0] CH_IDX = (n == 0) ? `CBO_CKS0_INDEX : `CBO_CKS1_INDEX;
			reg [7:0] cks_q;

			assign wr_hit[n] = (wr_index == CH_IDX);

			// Reserved bits 6..4 are never stored and read as zero
			always @(posedge core_clk_i) begin
				if (reset_i) begin
					cks_q <= `CBO_CKS_RESET; // Output disabled after reset
				end else if (wr_exec && wr_hit[n] && w_strb_q[0]) begin
					cks_q <= {w_data_q[`CBO_ENABLE_BIT], 3'h0, w_data_q[`CBO_SOURCE_BIT:0]};
				end
			end

			assign cks_flat[8*n+7:8*n] = cks_q;

			cbo_clock_divider #(
				.CNT_W(`CBO_CNT_W)
			) u_div (
				.core_clk_i(core_clk_i),
				.reset_i(reset_i),
				.enable_i(cks_q[`CBO_ENABLE_BIT]),
				.source_sel_i(cks_q[`CBO_SOURCE_BIT]),
				.div_code_i(cks_q[`CBO_DIV_MSB:`CBO_DIV_LSB]),
				.sub_level_i(sub_level_q),
				.sub_tick_i(sub_tick),
				.pin_o(pin_w[n])
			);
		end
	endgenerate

	// Pins leave the top through their own flops, one cycle behind the divider
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			pin_q <= {N_CH{1'b0}};
		end else begin
			pin_q <= pin_w;
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	reg arready_q;
	reg rvalid_q;
	reg rvalid_d;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg [1:0] rresp_q;
	reg [1:0] rresp_d;
	wire ar_take;
	wire [`CBO_IDX_W-1:0] rd_index;

	assign ar_take = s_axi_arvalid_i & arready_q;
	assign rd_index = s_axi_araddr_i[ADDR_W-1:2];

	// Address decode and read data; unmapped reads answer an error with zero
	always @* begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (ar_take) begin
			rvalid_d = 1'b1;
			rresp_d = `CBO_RESP_OKAY;
			if (rd_index == `CBO_CKS0_INDEX) begin
				rdata_d = {24'h0, cks_flat[7:0]};
			end else if (rd_index == `CBO_CKS1_INDEX) begin
				rdata_d = {24'h0, cks_flat[15:8]};
			end else if (rd_index == `CBO_STATUS_INDEX) begin
				rdata_d = {27'h0, sub_level_q, 2'h0, pin_q};
			end else begin
				rdata_d = 32'h0;
				rresp_d = `CBO_RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_d = 1'b0;
		end
	end

	// One read at a time: the address channel closes until the data is taken
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `CBO_RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d & ~ar_take;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;
	assign clock_buzzer_pin_o = pin_q;

endmodule

`default_nettype wire

/* File: logic/cbo_map.vh */
/*
 * Register map, field positions, reset values and bus codes of the
 * clock and buzzer output unit.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef CBO_MAP_VH
`define CBO_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CBO_IDX_W 20
`define CBO_CKS0_INDEX 20'hfffa5
`define CBO_CKS1_INDEX 20'hfffa6
`define CBO_STATUS_INDEX 20'hfffa7

// ****************************************************************
// Select register fields and reset value
// ****************************************************************
`define CBO_CKS_RESET 8'h00
`define CBO_ENABLE_BIT 7
`define CBO_SOURCE_BIT 3
`define CBO_DIV_MSB 2
`define CBO_DIV_LSB 0

// ****************************************************************
// Divider layout
// ****************************************************************
`define CBO_CNT_W 13
`define CBO_MAIN_BIT_CODE5 4'ha
`define CBO_MAIN_BIT_CODE6 4'hb
`define CBO_MAIN_BIT_CODE7 4'hc

// ****************************************************************
// Clock rate and bus response codes
// ****************************************************************
`define CBO_CORE_CLK_HZ 20000000
`define CBO_RESP_OKAY 2'b00
`define CBO_RESP_SLVERR 2'b10

`endif

/* File: logic/cbo_clock_divider.v */
/*
 * One clock output channel: picks the main clock or the subsystem clock,
 * divides it and drives the output pin level from a flip-flop.
 * Assumes the subsystem clock arrives as a registered level plus a
 * one-cycle pulse at each of its rising edges, both in the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbo_map.vh"

module cbo_clock_divider #(
	parameter CNT_W = `CBO_CNT_W
) (
	input wire core_clk_i,
	input wire reset_i,
	input wire enable_i,
	input wire source_sel_i,
	input wire [2:0] div_code_i,
	input wire sub_level_i,
	input wire sub_tick_i,
	output wire pin_o
);

	reg [3:0] sel_q;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg pin_q;
	reg pin_d;
	reg [3:0] bit_sel;
	reg tick;

	// ****************************************************************
	// Tap selection from the applied setting
	// ****************************************************************
	// Main codes 0..4 use taps 0..3, codes 5..7 jump to the slow taps
	always @* begin
		bit_sel = 4'h0;
		if (!sel_q[3]) begin
			case (sel_q[2:0])
				3'h0: bit_sel = 4'h0; // Undivided main is not reachable from a flop
				3'h1: bit_sel = 4'h0;
				3'h2: bit_sel = 4'h1;
				3'h3: bit_sel = 4'h2;
				3'h4: bit_sel = 4'h3;
				3'h5: bit_sel = `CBO_MAIN_BIT_CODE5;
				3'h6: bit_sel = `CBO_MAIN_BIT_CODE6;
				default: bit_sel = `CBO_MAIN_BIT_CODE7;
			endcase
		end else begin
			// Subsystem codes 1..7 use taps 0..6
			bit_sel = {1'b0, sel_q[2:0]} - 4'h1;
		end
	end

	// Next count and next pin level
	always @* begin
		tick = sel_q[3] ? sub_tick_i : 1'b1;
		cnt_d = cnt_q;
		if (tick) begin
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		if (sel_q[3] && (sel_q[2:0] == 3'h0)) begin
			pin_d = sub_level_i; // Undivided subsystem clock follows its level
		end else begin
			pin_d = cnt_d[bit_sel];
		end
	end

	// ****************************************************************
	// Counter, applied setting and pin flop
	// ****************************************************************
	// The setting is only taken while disabled, so a careless write while
	// running cannot make a runt pulse; a stopped subsystem clock simply
	// freezes the counter and the pin keeps its last level
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			sel_q <= 4'h0;
			cnt_q <= {CNT_W{1'b0}};
			pin_q <= 1'b0;
		end else if (!enable_i) begin
			sel_q <= {source_sel_i, div_code_i};
			cnt_q <= {CNT_W{1'b0}};
			pin_q <= 1'b0; // Static low while disabled
		end else begin
			cnt_q <= cnt_d;
			pin_q <= pin_d;
		end
	end

	assign pin_o = pin_q;

endmodule

`default_nettype wire

/* File: tb/cbo_asserts.sv */
/* Assertions on the output pins of the clock output unit, bound to cbo_top.
   Assumes a write offers address and data together, so both are taken at one edge. */
`timescale 1ns/1ps
`default_nettype none
`include "cbo_map.vh"
module cbo_asserts #(
	parameter ADDR_W = 22,
	parameter N_CH = 2
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic sub_clk_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [N_CH-1:0] clock_buzzer_pin_o
);
// ****************************************
// Shadow of channel 0
// ****************************************
logic [7:0] cfg_q;
logic [13:0] run_q;
logic [1:0] seen_q;
logic [2:0] age_q;
logic [2:0] dis_q;
logic pin_q;
logic sub_q;
wire tog = clock_buzzer_pin_o[0] != pin_q;
wire [2:0] c = cfg_q[2:0];
wire [13:0] half = (c < 3'd2) ? 14'd1 : (c < 3'd5) ? 14'd1 << (c - 3'd1) : 14'd1 << ({1'b0, c} + 4'd5);
wire wr0 = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && s_axi_wstrb_i[0]
	&& s_axi_awaddr_i[ADDR_W-1:2] == `CBO_CKS0_INDEX;

// Toggle count is cleared by every byte-0 write to the channel 0 select register so a partial first level is never judged
always @(posedge core_clk_i) begin
	pin_q <= clock_buzzer_pin_o[0];
	sub_q <= sub_clk_i;
	if (reset_i) begin
		cfg_q <= 8'h00;
		seen_q <= 2'd0;
		run_q <= 14'd0;
		age_q <= 3'd0;
		dis_q <= 3'd0;
	end else begin
		if (wr0) cfg_q <= s_axi_wdata_i[7:0];
		if (wr0) seen_q <= 2'd0;
		else if (tog && seen_q != 2'd2) seen_q <= seen_q + 2'd1;
		run_q <= tog ? 14'd1 : run_q + 14'd1;
		age_q <= (sub_clk_i != sub_q) ? 3'd0 : age_q + {2'd0, age_q != 3'd7};
		dis_q <= cfg_q[7] ? 3'd0 : dis_q + {2'd0, dis_q != 3'd7};
	end
end

default clocking @(posedge core_clk_i); endclocking
default disable iff (reset_i);

rst_pins_low_a: assert property ($fell(reset_i) |-> clock_buzzer_pin_o == '0)
	else $error("pin high right after reset");
dis_pin_low_a: assert property (dis_q == 3'd7 |-> !clock_buzzer_pin_o[0])
	else $error("pin not low while disabled");
main_half_a: assert property (tog && seen_q == 2'd2 && cfg_q[7] && !cfg_q[3] |-> run_q == half)
	else $error("main half period wrong");
main_bound_a: assert property (seen_q == 2'd2 && cfg_q[7] && !cfg_q[3] |-> run_q <= half)
	else $error("main output stuck");
// The first toggle after a write may follow the enable, not a sub edge, so it is skipped
sub_edge_a: assert property (tog && seen_q != 2'd0 && cfg_q[7] && cfg_q[3] |-> age_q <= 3'd5)
	else $error("sub output moved off a sub edge");
endmodule
bind cbo_top cbo_asserts #(.ADDR_W(ADDR_W), .N_CH(N_CH)) u_chk (.core_clk_i, .reset_i, .sub_clk_i,
	.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
	.s_axi_wvalid_i, .s_axi_wready_o, .clock_buzzer_pin_o);
`default_nettype wire

/* File: tb/cbo_pin_meter.sv */
/* External circuit on one output pin: measures the length of each level.
   Assumes the pin is a registered level in the core clock domain. */
`timescale 1ns/1ps
`default_nettype none
module cbo_pin_meter (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic [13:0] half_o,
	output logic [7:0] edges_o
);
logic pin_q;
logic [13:0] run_q;
// Listener only; it never loads the pin, so it cannot mask a stuck output
always @(posedge core_clk_i) begin
	pin_q <= pin_i;
	if (rst_i) begin
		edges_o <= 8'd0;
		run_q <= 14'd0;
		half_o <= 14'd0;
	end else if (pin_i != pin_q) begin
		half_o <= run_q;
		edges_o <= edges_o + 8'd1;
		run_q <= 14'd1;
	end else begin
		run_q <= run_q + 14'd1;
	end
end
endmodule
`default_nettype wire

/* File: tb/cbo_tb_top.sv */
/* Self-checking bench for cbo_top: register bus, main and sub divided outputs.
   Assumes a sub clock at one sixteenth of the core rate, made here. */
`timescale 1ns/1ps
`default_nettype none
`include "cbo_map.vh"
module cbo_tb_top;
localparam logic [21:0] A0 = {`CBO_CKS0_INDEX, 2'b00};
localparam logic [21:0] A1 = {`CBO_CKS1_INDEX, 2'b00};
localparam logic [21:0] AS = {`CBO_STATUS_INDEX, 2'b00};
logic clk = 1'b0, rst = 1'b1, sub_clk = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
logic [21:0] awa = '0, ara = '0;
logic [31:0] wd = '0;
logic [3:0] ws = '0, sdiv = '0;
wire awr, wr, bv, arr, rv;
wire [1:0] br, rr, pin;
wire [31:0] rd;
wire [13:0] h0, h1;
wire [7:0] e0, e1;
int miscompares = 0, total_checks = 0;

always #25 clk = ~clk;
// Sub clock kept synchronous, as the unit expects
always @(posedge clk) begin
	sdiv <= sdiv + 4'd1;
	sub_clk <= sdiv[3];
end

cbo_top u_dut (.core_clk_i(clk), .reset_i(rst), .sub_clk_i(sub_clk), .s_axi_awaddr_i(awa),
	.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
	.s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
	.s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
	.s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
	.clock_buzzer_pin_o(pin));
cbo_pin_meter u_m0 (.core_clk_i(clk), .rst_i(rst), .pin_i(pin[0]), .half_o(h0), .edges_o(e0));
cbo_pin_meter u_m1 (.core_clk_i(clk), .rst_i(rst), .pin_i(pin[1]), .half_o(h1), .edges_o(e1));

// ****************************************
// Bus and compare tasks
// ****************************************
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	total_checks++;
	if (seen !== exp) begin
		miscompares++;
		$display("wrong value %s expected %h seen %h", nm, exp, seen);
	end
endtask

task automatic wrc(input logic [21:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
	int n;
	n = 0;
	@(posedge clk);
	awa <= a;
	wd <= d;
	ws <= s;
	awv <= 1'b1;
	wv <= 1'b1;
	bre <= 1'b1;
	do begin
		@(posedge clk);
		n++;
		if (awr) awv <= 1'b0;
		if (wr) wv <= 1'b0;
	end while (!bv && n < 100);
	bre <= 1'b0;
	chk("bvalid", bv, 1'b1);
	chk("bresp", br, r);
endtask

task automatic rdc(input logic [21:0] a, input logic [31:0] e, input logic [1:0] r);
	int n;
	n = 0;
	@(posedge clk);
	ara <= a;
	arv <= 1'b1;
	rre <= 1'b1;
	do begin
		@(posedge clk);
		n++;
		if (arr) arv <= 1'b0;
	end while (!rv && n < 100);
	rre <= 1'b0;
	chk("rvalid", rv, 1'b1);
	chk("rdata", rd, e);
	chk("rresp", rr, r);
endtask

// ****************************************
// Scenarios
// ****************************************
task automatic regs;
	chk("pins after reset", pin, 2'b00);
	rdc(A0, 32'h0, 2'b00);
	rdc(A1, 32'h0, 2'b00);
	wrc(A1, 32'hffffffff, 4'hf, 2'b00);
	rdc(A1, 32'h8f, 2'b00);
	wrc(A1, 32'h0, 4'h0, 2'b00);
	rdc(A1, 32'h8f, 2'b00);
	wrc(A1, 32'h0f, 4'h1, 2'b00);
	rdc(A1, 32'h0f, 2'b00);
	wrc(AS, 32'hff, 4'h1, 2'b00);
	wrc(22'h0, 32'h81, 4'h1, 2'b10);
	rdc(22'h0, 32'h0, 2'b10);
	$display("test registers done");
endtask

// Enable one setting, time a full level on the pin, then switch off
task automatic per(input logic [21:0] a, input int ch, input logic [7:0] cfg, input logic [13:0] h);
	logic [7:0] e;
	int n;
	wrc(a, {24'h0, cfg}, 4'h1, 2'b00);
	wrc(a, {24'h0, cfg | 8'h80}, 4'h1, 2'b00);
	e = ch ? e1 : e0;
	n = 0;
	while (8'((ch ? e1 : e0) - e) < 8'd3 && n < 20000) begin
		@(posedge clk);
		n++;
	end
	chk("edge wait timed out", n >= 20000, 1'b0);
	chk("half period", ch ? h1 : h0, h);
	wrc(a, {24'h0, cfg}, 4'h1, 2'b00);
	repeat (4) @(posedge clk);
	chk("pin when disabled", pin[ch], 1'b0);
	$display("test setting %h done", cfg);
endtask

task test_done;
	$display("checks %0d mismatches %0d", total_checks, miscompares);
	if (miscompares == 0 && total_checks > 0) begin
		$display("DONE - PASS");
	end else begin
		$display("DONE - FAIL");
	end
	$finish;
endtask

initial begin
	repeat (16) @(posedge clk);
	rst <= 1'b0;
	repeat (2) @(posedge clk);
	regs();
	// Undivided main clock is left out: too fast at this core rate
	for (int c = 1; c < 8; c++) begin
		per(A0, 0, 8'(c), c < 5 ? 14'd1 << (c - 1) : 14'd1 << (c + 5));
	end
	for (int c = 0; c < 8; c++) begin
		per(A0, 0, 8'(8 + c), 14'd8 << c);
	end
	per(A1, 1, 8'h02, 14'd2);
	per(A1, 1, 8'h0b, 14'd64);
	test_done();
end

// Watchdog well beyond the longest expected run
initial begin
	repeat (60000) @(posedge clk);
	miscompares++;
	test_done();
end
endmodule
`default_nettype wire
